/* File: sbc_regs_pkg.sv */
/*
  constants shared by the watchdog / wake control register bank:
  serial frame layout, register addresses, field positions, masks,
  power-on, restart and fail-safe values.
  assumes nothing of its surroundings.
*/
`default_nettype none

package sbc_regs_pkg;

  // serial frame: bit 15 write flag, bits 14:8 address, bits 7:0 data
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned FRAME_WRITE_BIT = 15;
  localparam int unsigned FRAME_ADDR_MSB = 14;
  localparam int unsigned FRAME_ADDR_LSB = 8;
  localparam logic [4:0] FRAME_COUNT_FULL = 5'h10;

  // register addresses
  localparam logic [6:0] ADDR_WDOG = 7'h03;
  localparam logic [6:0] ADDR_XCVR0 = 7'h04;
  localparam logic [6:0] ADDR_IWAKE = 7'h06;
  localparam logic [6:0] ADDR_EWAKE = 7'h07;

  // field positions
  localparam int unsigned WDOG_CHECKSUM_BIT = 7;
  localparam int unsigned WDOG_STOP_A_BIT = 6;
  localparam int unsigned WDOG_TYPE_BIT = 5;
  localparam int unsigned WDOG_BUS_WAKE_BIT = 4;
  localparam int unsigned WDOG_MAX3_BIT = 3;
  localparam int unsigned WDOG_PERIOD_LSB = 0;
  localparam int unsigned XCVR0_MODE_LSB = 0;
  localparam int unsigned IWAKE_CYCLIC_BIT = 6;
  localparam int unsigned IWAKE_THRESH_LSB = 4;
  localparam int unsigned IWAKE_STOP_B_BIT = 2;
  localparam int unsigned IWAKE_FAST_BAT_BIT = 0;
  localparam int unsigned EWAKE_PIN_BIT = 0;

  // writable bits; all others read as zero
  localparam logic [7:0] WDOG_MASK = 8'hFF;
  localparam logic [7:0] XCVR0_MASK = 8'h03;
  localparam logic [7:0] IWAKE_MASK = 8'h75;
  localparam logic [7:0] EWAKE_MASK = 8'h01;

  // power-on / soft reset values
  localparam logic [7:0] WDOG_RESET = 8'h14;
  localparam logic [7:0] XCVR0_RESET = 8'h00;
  localparam logic [7:0] IWAKE_RESET = 8'h01;
  localparam logic [7:0] EWAKE_RESET = 8'h01;

  // restart: kept bits and forced ones
  localparam logic [7:0] WDOG_RESTART_KEEP = 8'hB8;
  localparam logic [7:0] WDOG_RESTART_SET = 8'h04;
  localparam logic [7:0] XCVR0_RESTART_KEEP = 8'h03;
  localparam logic [7:0] IWAKE_RESTART_KEEP = 8'h71;
  localparam logic [7:0] EWAKE_RESTART_KEEP = 8'h01;

  // fail-safe entry values
  localparam logic [7:0] XCVR0_FAILSAFE = 8'h01;
  localparam logic [7:0] EWAKE_FAILSAFE = 8'h01;

  localparam logic [1:0] MAX_WDOG_RESETS = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_STOP,
    MODE_SOFT_RESET
  } device_mode_t;

  typedef enum logic [1:0] {
    XCVR_OFF,
    XCVR_WAKE_CAPABLE,
    XCVR_RECEIVE_ONLY,
    XCVR_NORMAL
  } xcvr_mode_t;

endpackage

`default_nettype wire

/* File: sbc_watchdog_wake_ctrl_regs.sv */
/*
  watchdog, transceiver 0 and wake source control registers, reached
  over the 16-bit serial port; power-on, soft reset, restart and
  fail-safe values; stop-mode watchdog request, bus-wake start and
  limit on watchdog-failure resets.
  assumes event inputs are single-cycle pulses on ref_clk.
*/
// Operation
// - watchdog bit 6 requests stop-mode deactivation
// - internal wake bit 2 requests stop deactivation
// - watchdog bit 5 selects time-out or window
// - bit 4 starts watchdog after stop bus wake
// - bit 3 stops resets after three failures when config_1_or_3 is set
// - restart keeps 7,5,4,3, clears 6, period 100
// - fail-safe rewrites bus and external wake registers
// - fail-safe forces external wake to 0000 0001
// - internal wake bit 6 enables cyclic wake
// - bits 5:4 select battery monitor threshold
// - bit 0 enables fast battery monitoring, default on
// - external wake bit 0 enables wake pin
// - reserved bits always read zero
// - restart clears internal wake bits 7, 3:1
// - restart clears external wake bits 7:1
// - device mode 00 normal ... 10 stop
`default_nettype none

module sbc_watchdog_wake_ctrl_regs
  import sbc_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial control port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // device state and events
  input wire logic [1:0] device_mode,
  input wire logic config_1_or_3,
  input wire logic soft_reset_evt,
  input wire logic restart_evt,
  input wire logic failsafe_evt,
  // device-side field updates
  input wire logic xcvr_mode_load,
  input wire logic [1:0] xcvr_mode_value,
  input wire logic wake_pin_hw_clear,
  // watchdog engine events
  input wire logic wdog_fail_evt,
  input wire logic wdog_serviced,
  input wire logic bus_wake_evt,
  // watchdog configuration
  output logic wdog_stop_disable_a,
  output logic wdog_stop_disable_b,
  output logic wdog_type_select,
  output logic wdog_start_on_bus_wake,
  output logic wdog_reset_limit,
  output logic [2:0] wdog_period_select,
  output logic [10:0] wdog_period_ms,
  output logic wdog_period_reserved,
  output logic checksum_error,
  // watchdog control results
  output logic wdog_deactivated_in_stop,
  output logic wdog_long_window_start,
  output logic wdog_reset_req,
  // transceiver and wake configuration
  output logic [1:0] transceiver_zero_mode,
  output logic cyclic_wake_enable,
  output logic [1:0] battery_threshold_select,
  output logic fast_battery_monitor_enable,
  output logic wake_pin_source_enable
);

  logic [7:0] wdog_reg;
  logic [7:0] xcvr0_reg;
  logic [7:0] iwake_reg;
  logic [7:0] ewake_reg;
  logic [6:0] last_addr_reg;
  logic [15:0] tx_word_reg;
  logic [15:0] rx_word;
  logic frame_valid;
  logic [1:0] fail_count_reg;
  logic checksum_error_reg;
  logic deactivated_reg;
  logic long_window_reg;
  logic reset_req_reg;
  logic wr_frame;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_wdog;
  logic wr_xcvr0;
  logic wr_iwake;
  logic wr_ewake;
  logic wdog_parity_bad;
  logic in_stop;
  logic block_reset;

  // writable-bit mask per address, applied on the write path only
  function automatic logic [7:0] field_mask(input logic [6:0] addr);
    case (addr)
      ADDR_WDOG: field_mask = WDOG_MASK;
      ADDR_XCVR0: field_mask = XCVR0_MASK;
      ADDR_IWAKE: field_mask = IWAKE_MASK;
      ADDR_EWAKE: field_mask = EWAKE_MASK;
      default: field_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] restart_value(input logic [7:0] cur,
                                               input logic [7:0] keep,
                                               input logic [7:0] set);
    restart_value = (cur & keep) | set;
  endfunction

  spi_frame_port u_port (
    .ref_clk(ref_clk),
    .reset(reset),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n),
    .tx_word(tx_word_reg),
    .rx_word(rx_word),
    .frame_valid(frame_valid)
  );

  assign wr_frame = frame_valid && rx_word[FRAME_WRITE_BIT];
  assign wr_addr = rx_word[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
  assign wr_data = rx_word[7:0] & field_mask(wr_addr);
  assign wdog_parity_bad = ^rx_word[7:0];
  assign wr_wdog = wr_frame && wr_addr == ADDR_WDOG && !wdog_parity_bad;
  assign wr_xcvr0 = wr_frame && wr_addr == ADDR_XCVR0;
  assign wr_iwake = wr_frame && wr_addr == ADDR_IWAKE;
  assign wr_ewake = wr_frame && wr_addr == ADDR_EWAKE;
  assign in_stop = device_mode == MODE_STOP;

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      wdog_reg <= WDOG_RESET;
    end else if (restart_evt) begin
      wdog_reg <= restart_value(wdog_reg, WDOG_RESTART_KEEP, WDOG_RESTART_SET);
    end else if (wr_wdog) begin
      wdog_reg <= wr_data;
    end
  end

  // a write with wrong parity is refused and flagged until a good one
  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      checksum_error_reg <= 1'b0;
    end else if (wr_frame && wr_addr == ADDR_WDOG) begin
      checksum_error_reg <= wdog_parity_bad;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      xcvr0_reg <= XCVR0_RESET;
    end else if (failsafe_evt) begin
      xcvr0_reg <= XCVR0_FAILSAFE;
    end else if (restart_evt) begin
      xcvr0_reg <= restart_value(xcvr0_reg, XCVR0_RESTART_KEEP, 8'h00);
    end else if (xcvr_mode_load) begin
      xcvr0_reg <= {6'h00, xcvr_mode_value};
    end else if (wr_xcvr0) begin
      xcvr0_reg <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      iwake_reg <= IWAKE_RESET;
    end else if (restart_evt) begin
      iwake_reg <= restart_value(iwake_reg, IWAKE_RESTART_KEEP, 8'h00);
    end else if (wr_iwake) begin
      iwake_reg <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      ewake_reg <= EWAKE_RESET;
    end else if (failsafe_evt) begin
      ewake_reg <= EWAKE_FAILSAFE;
    end else if (restart_evt) begin
      ewake_reg <= restart_value(ewake_reg, EWAKE_RESTART_KEEP, 8'h00);
    end else if (wake_pin_hw_clear) begin
      ewake_reg <= 8'h00;
    end else if (wr_ewake) begin
      ewake_reg <= wr_data;
    end
  end

  // read answer: status byte and the register addressed by the last frame
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_addr_reg <= 7'h00;
    end else if (frame_valid) begin
      last_addr_reg <= wr_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_word_reg <= 16'h0000;
    end else begin
      case (last_addr_reg)
        ADDR_WDOG: tx_word_reg <= {7'h00, checksum_error_reg, wdog_reg};
        ADDR_XCVR0: tx_word_reg <= {7'h00, checksum_error_reg, xcvr0_reg};
        ADDR_IWAKE: tx_word_reg <= {7'h00, checksum_error_reg, iwake_reg};
        ADDR_EWAKE: tx_word_reg <= {7'h00, checksum_error_reg, ewake_reg};
        default: tx_word_reg <= {7'h00, checksum_error_reg, 8'h00};
      endcase
    end
  end

  // both deactivation bits must be set to stop the watchdog in stop mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      deactivated_reg <= 1'b0;
    end else begin
      deactivated_reg <= in_stop && wdog_reg[WDOG_STOP_A_BIT]
                         && iwake_reg[IWAKE_STOP_B_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      long_window_reg <= 1'b0;
    end else begin
      long_window_reg <= bus_wake_evt && in_stop && wdog_reg[WDOG_BUS_WAKE_BIT];
    end
  end

  assign block_reset = wdog_reg[WDOG_MAX3_BIT] && config_1_or_3
                       && fail_count_reg == MAX_WDOG_RESETS;

  // a failure in the same cycle as a service still counts
  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset_evt) begin
      fail_count_reg <= 2'h0;
    end else if (wdog_fail_evt) begin
      if (fail_count_reg != MAX_WDOG_RESETS) begin
        fail_count_reg <= fail_count_reg + 2'h1;
      end
    end else if (wdog_serviced) begin
      fail_count_reg <= 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= wdog_fail_evt && !block_reset;
    end
  end

  wdog_period_decode u_period (
    .ref_clk(ref_clk),
    .reset(reset),
    .period_code(wdog_reg[WDOG_PERIOD_LSB +: 3]),
    .period_ms(wdog_period_ms),
    .period_reserved(wdog_period_reserved)
  );

  assign wdog_stop_disable_a = wdog_reg[WDOG_STOP_A_BIT];
  assign wdog_stop_disable_b = iwake_reg[IWAKE_STOP_B_BIT];
  assign wdog_type_select = wdog_reg[WDOG_TYPE_BIT];
  assign wdog_start_on_bus_wake = wdog_reg[WDOG_BUS_WAKE_BIT];
  assign wdog_reset_limit = wdog_reg[WDOG_MAX3_BIT];
  assign wdog_period_select = wdog_reg[WDOG_PERIOD_LSB +: 3];
  assign checksum_error = checksum_error_reg;
  assign wdog_deactivated_in_stop = deactivated_reg;
  assign wdog_long_window_start = long_window_reg;
  assign wdog_reset_req = reset_req_reg;
  assign transceiver_zero_mode = xcvr0_reg[XCVR0_MODE_LSB +: 2];
  assign cyclic_wake_enable = iwake_reg[IWAKE_CYCLIC_BIT];
  assign battery_threshold_select = iwake_reg[IWAKE_THRESH_LSB +: 2];
  assign fast_battery_monitor_enable = iwake_reg[IWAKE_FAST_BAT_BIT];
  assign wake_pin_source_enable = ewake_reg[EWAKE_PIN_BIT];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_plain_restart;
    restart_evt && !soft_reset_evt;
  endsequence

  sequence s_failsafe_entry;
    failsafe_evt && !soft_reset_evt;
  endsequence

  a_checksum_refused: assert property (
    wr_frame && wr_addr == ADDR_WDOG && wdog_parity_bad && !restart_evt && !soft_reset_evt
    |=> $stable(wdog_reg) && checksum_error)
    else $error("bad parity write changed watchdog register");

  a_restart_wdog: assert property (
    s_plain_restart |=> wdog_reg[WDOG_STOP_A_BIT] == 1'b0 && wdog_period_select == 3'h4
    && wdog_reg[7] == $past(wdog_reg[7]) && wdog_reg[5:3] == $past(wdog_reg[5:3]))
    else $error("watchdog register restart value wrong");

  a_restart_iwake: assert property (
    s_plain_restart |=> (iwake_reg & 8'h8E) == 8'h00
    && (iwake_reg & IWAKE_RESTART_KEEP) == ($past(iwake_reg) & IWAKE_RESTART_KEEP))
    else $error("internal wake restart value wrong");

  a_restart_ewake: assert property (
    s_plain_restart and !failsafe_evt |=> ewake_reg == ($past(ewake_reg) & 8'h01))
    else $error("external wake restart value wrong");

  a_failsafe_wake: assert property (
    s_failsafe_entry |=> ewake_reg == 8'h01 ##1 (wake_pin_source_enable
    || $past(wake_pin_hw_clear) || $past(wr_ewake) || $past(restart_evt)))
    else $error("fail-safe did not force wake pin source");

  a_failsafe_xcvr: assert property (
    s_failsafe_entry |=> transceiver_zero_mode == XCVR_WAKE_CAPABLE)
    else $error("fail-safe did not leave transceiver wake capable");

  a_reserved_zero: assert property (
    (iwake_reg & ~IWAKE_MASK) == 8'h00 && (ewake_reg & ~EWAKE_MASK) == 8'h00
    && (xcvr0_reg & ~XCVR0_MASK) == 8'h00)
    else $error("reserved bit holds a one");

  a_stop_deactivate: assert property (
    in_stop && wdog_stop_disable_a && wdog_stop_disable_b |=> wdog_deactivated_in_stop)
    else $error("watchdog not deactivated in stop mode");

  a_bus_wake_start: assert property (
    bus_wake_evt && (!in_stop || !wdog_start_on_bus_wake) |=> !wdog_long_window_start)
    else $error("long window started without enable");

  a_reset_limited: assert property (
    wdog_fail_evt && block_reset |=> !wdog_reset_req)
    else $error("reset issued past the limit");

  a_reset_always: assert property (
    wdog_fail_evt && !wdog_reset_limit |=> wdog_reset_req)
    else $error("watchdog failure gave no reset");

  a_fast_bat_default: assert property (
    $past(soft_reset_evt) |-> fast_battery_monitor_enable)
    else $error("fast battery monitor not on after soft reset");

endmodule

`default_nettype wire

/* File: sbc_watchdog_wake_ctrl_regs_bench.sv */
/*
  self-checking bench for the watchdog / wake register bank.
  assumes the design files and spi_host_model are compiled first.
*/
`default_nettype none

module sbc_watchdog_wake_ctrl_regs_bench
  import sbc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, miso_oe_n;
  logic [1:0] device_mode;
  logic config_1_or_3 = 1'b0;
  logic [1:0] xcvr_mode_value;
  // 0 fail, 1 bus wake, 2 restart, 3 fail-safe, 4 soft reset, 5 pin clear, 6 mode load, 7 service
  logic [7:0] ev = 8'h00;
  logic sa, sb, wtype, bwake, lim, per_res, cks_err, deact, long_win, rst_req, cyc, fast, pin;
  logic [2:0] per;
  logic [10:0] per_ms;
  logic [1:0] xcvr, thr;
  logic [7:0] wd_out, iw_out;
  int num_errors = 0;
  int checked = 0;

  assign wd_out = {1'b0, sa, wtype, bwake, lim, per};
  assign iw_out = {1'b0, cyc, thr, 1'b0, sb, 1'b0, fast};

  always #50 ref_clk = ~ref_clk;

  spi_host_model spi_host_model_i (.ref_clk(ref_clk), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  sbc_watchdog_wake_ctrl_regs sbc_watchdog_wake_ctrl_regs_i (.ref_clk(ref_clk), .reset(reset),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(miso_oe_n), .device_mode(device_mode), .config_1_or_3(config_1_or_3),
    .soft_reset_evt(ev[4]), .restart_evt(ev[2]), .failsafe_evt(ev[3]),
    .xcvr_mode_load(ev[6]), .xcvr_mode_value(xcvr_mode_value), .wake_pin_hw_clear(ev[5]),
    .wdog_fail_evt(ev[0]), .wdog_serviced(ev[7]), .bus_wake_evt(ev[1]),
    .wdog_stop_disable_a(sa), .wdog_stop_disable_b(sb), .wdog_type_select(wtype),
    .wdog_start_on_bus_wake(bwake), .wdog_reset_limit(lim), .wdog_period_select(per),
    .wdog_period_ms(per_ms), .wdog_period_reserved(per_res), .checksum_error(cks_err),
    .wdog_deactivated_in_stop(deact), .wdog_long_window_start(long_win),
    .wdog_reset_req(rst_req), .transceiver_zero_mode(xcvr), .cyclic_wake_enable(cyc),
    .battery_threshold_select(thr), .fast_battery_monitor_enable(fast),
    .wake_pin_source_enable(pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] rx;
    spi_host_model_i.xfer({1'b1, a, d}, 16, rx);
  endtask

  // the answer shows in the frame after the one that addressed it
  task automatic rd(input logic [6:0] a, output logic [15:0] rx);
    spi_host_model_i.xfer({1'b0, a, 8'h00}, 16, rx);
    spi_host_model_i.xfer({1'b0, a, 8'h00}, 16, rx);
  endtask

  task automatic evt(input int k, output logic [15:0] n);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev <= 8'h00;
    n = '0;
    repeat (4) begin
      @(posedge ref_clk);
      n += ((k == 0) ? rst_req : long_win) === 1'b1;
    end
  endtask

  task automatic t_reset;
    check(wd_out, 8'h14);
    check(xcvr, 2'h0);
    check(iw_out, 8'h01);
    check(pin, 1'b1);
    check(per_ms, 11'h0C8);
    check(miso_oe_n, 1'b1);
  endtask

  task automatic t_rw;
    logic [6:0] ad[4] = '{ADDR_WDOG, ADDR_XCVR0, ADDR_IWAKE, ADDR_EWAKE};
    logic [7:0] rb[4] = '{8'hFF, 8'h03, 8'h75, 8'h01};
    logic [15:0] rx;
    for (int i = 0; i < 4; i++) begin
      wr(ad[i], 8'hFF);
      rd(ad[i], rx);
      check(rx, {8'h00, rb[i]});
    end
    wr(7'h05, 8'h00);
    check(iw_out, 8'h75);
    check({per_res, per_ms}, 12'h800);
    for (int i = 0; i < 4; i++)
      wr(ad[i], 8'h00);
    check(iw_out, 8'h00);
    check(pin, 1'b0);
  endtask

  task automatic t_period;
    logic [10:0] ms[7] = '{10, 20, 50, 100, 200, 500, 1000};
    for (int c = 0; c < 7; c++) begin
      spi_host_model_i.wr_wdog({4'h0, 3'(c)});
      check({per_res, per_ms}, {1'b0, ms[c]});
    end
  endtask

  task automatic t_parity;
    logic [15:0] rx;
    wr(ADDR_WDOG, 8'h01);
    check({cks_err, wd_out}, 9'h106);
    spi_host_model_i.xfer({1'b1, ADDR_XCVR0, 8'h03}, 15, rx);
    check(xcvr, 2'h0);
    spi_host_model_i.wr_wdog(7'h06);
    check(cks_err, 1'b0);
  endtask

  task automatic t_stop;
    logic [15:0] n;
    spi_host_model_i.wr_wdog(7'h40);
    wr(ADDR_IWAKE, 8'h04);
    device_mode <= 2'h2;
    repeat (3) @(posedge ref_clk);
    check({deact, sa, sb}, 3'h7);
    device_mode <= 2'h0;
    repeat (3) @(posedge ref_clk);
    check(deact, 1'b0);
    device_mode <= 2'h2;
    wr(ADDR_IWAKE, 8'h00);
    check(deact, 1'b0);
    spi_host_model_i.wr_wdog(7'h30);
    check(wtype, 1'b1);
    evt(1, n);
    check(n, 1);
    spi_host_model_i.wr_wdog(7'h00);
    evt(1, n);
    check(n, 0);
  endtask

  task automatic t_limit;
    logic [15:0] n;
    logic [15:0] exp[4] = '{1, 1, 1, 0};
    device_mode <= 2'h0;
    config_1_or_3 <= 1'b1;
    evt(0, n);
    check(n, 1);
    evt(7, n);
    spi_host_model_i.wr_wdog(7'h08);
    for (int i = 0; i < 4; i++) begin
      evt(0, n);
      check(n, exp[i]);
    end
    config_1_or_3 <= 1'b0;
    evt(0, n);
    check(n, 1);
  endtask

  task automatic t_restart;
    logic [15:0] n;
    logic [15:0] rx;
    spi_host_model_i.wr_wdog(7'h7B);
    wr(ADDR_IWAKE, 8'h75);
    wr(ADDR_EWAKE, 8'h01);
    wr(ADDR_XCVR0, 8'h03);
    evt(2, n);
    check(iw_out, 8'h71);
    check(xcvr, 2'h3);
    rd(ADDR_WDOG, rx);
    check(rx, 16'h003C);
    rd(ADDR_EWAKE, rx);
    check(rx, 16'h0001);
  endtask

  task automatic t_failsafe;
    logic [15:0] n;
    wr(ADDR_EWAKE, 8'h00);
    evt(3, n);
    check(xcvr, 2'h1);
    check(pin, 1'b1);
    check(iw_out, 8'h71);
    xcvr_mode_value <= 2'h2;
    evt(6, n);
    check(xcvr, 2'h2);
    evt(5, n);
    check(pin, 1'b0);
    evt(4, n);
    check({wd_out, iw_out}, 16'h1401);
    check({xcvr, pin}, 3'h1);
  endtask

  initial begin
    @(posedge ref_clk);
    device_mode <= 2'h0;
    xcvr_mode_value <= 2'h0;
    repeat (7) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_rw();
    t_period();
    t_parity();
    t_stop();
    t_limit();
    t_restart();
    t_failsafe();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule

`default_nettype wire

/* File: spi_frame_port.sv */
/*
  16-bit serial frame port: shifts in on rising clock, out on falling
  clock, msb first. a frame counts only if exactly 16 bits came between
  select low and select high.
  assumes serial pins are synchronous to ref_clk and much slower.
*/
`default_nettype none

module spi_frame_port
  import sbc_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // frame side
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word,
  output logic frame_valid
);

  typedef enum logic {PORT_IDLE, PORT_SHIFT} port_state_t;

  port_state_t state_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [4:0] count_reg;
  logic [15:0] shift_in_reg;
  logic [15:0] shift_out_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  assign sclk_rise = spi_sclk && !sclk_reg;
  assign sclk_fall = !spi_sclk && sclk_reg;
  assign cs_rise = spi_cs_n && !cs_n_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      sclk_reg <= spi_sclk;
      cs_n_reg <= spi_cs_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= PORT_IDLE;
      count_reg <= 5'h00;
      shift_in_reg <= 16'h0000;
      shift_out_reg <= 16'h0000;
    end else begin
      case (state_reg)
        PORT_IDLE: begin
          if (!spi_cs_n) begin
            state_reg <= PORT_SHIFT;
            count_reg <= 5'h00;
            shift_out_reg <= tx_word;
          end
        end
        PORT_SHIFT: begin
          if (spi_cs_n) begin
            state_reg <= PORT_IDLE;
          end else if (sclk_rise) begin
            shift_in_reg <= {shift_in_reg[14:0], spi_mosi};
            if (count_reg != 5'h1F) begin
              count_reg <= count_reg + 5'h01;
            end
          end else if (sclk_fall && count_reg != 5'h00) begin
            shift_out_reg <= {shift_out_reg[14:0], 1'b0};
          end
        end
        default: state_reg <= PORT_IDLE;
      endcase
    end
  end

  // only a complete frame is handed on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_valid <= 1'b0;
      rx_word <= 16'h0000;
    end else begin
      frame_valid <= 1'b0;
      if (state_reg == PORT_SHIFT && cs_rise && count_reg == FRAME_COUNT_FULL) begin
        frame_valid <= 1'b1;
        rx_word <= shift_in_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso <= shift_out_reg[15];
      spi_miso_oe_n <= spi_cs_n;
    end
  end

  sequence s_frame_close;
    state_reg == PORT_SHIFT && cs_rise;
  endsequence

  a_short_frame_dropped: assert property (@(posedge ref_clk) disable iff (reset)
    s_frame_close and (count_reg != FRAME_COUNT_FULL) |=> !frame_valid)
    else $error("incomplete frame was accepted");

endmodule

`default_nettype wire

/* File: spi_host_model.sv */
/*
  host model: serial control master, idle-low clock, msb first.
  assumes the block samples its serial pins on ref_clk.
*/
`default_nettype none

module spi_host_model
  import sbc_regs_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // each clock level lasts 4 cycles, each data bit 8; released data line is inverted
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = '0;
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi <= word[15-i];
      hold(4);
      rx = {rx[14:0], spi_miso};
      spi_sclk <= 1'b1;
      hold(4);
      spi_sclk <= 1'b0;
    end
    hold(4);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    hold(4);
  endtask

  // checksum bit gives the whole byte even parity
  task automatic wr_wdog(input logic [6:0] bits);
    logic [15:0] rx;
    xfer({1'b1, ADDR_WDOG, ^bits, bits}, 16, rx);
  endtask
endmodule

`default_nettype wire

/* File: wdog_period_decode.sv */
/*
  decodes the watchdog period code into milliseconds, registered.
  assumes the code comes from a register in the same clock domain.
*/
`default_nettype none

module wdog_period_decode
  import sbc_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // code in
  input wire logic [2:0] period_code,
  // decoded period
  output logic [10:0] period_ms,
  output logic period_reserved
);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period_ms <= 11'h0C8;
      period_reserved <= 1'b0;
    end else begin
      period_reserved <= 1'b0;
      case (period_code)
        3'h0: period_ms <= 11'h00A;
        3'h1: period_ms <= 11'h014;
        3'h2: period_ms <= 11'h032;
        3'h3: period_ms <= 11'h064;
        3'h4: period_ms <= 11'h0C8;
        3'h5: period_ms <= 11'h1F4;
        3'h6: period_ms <= 11'h3E8;
        default: begin
          period_ms <= 11'h000;
          period_reserved <= 1'b1;
        end
      endcase
    end
  end

  a_period_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    period_code == 3'h7 |=> period_reserved && period_ms == 11'h000)
    else $error("reserved period code not flagged");

endmodule

`default_nettype wire
